// file: hw/sipg_defines.vh
`ifndef SIPG_DEFINES_VH
`define SIPG_DEFINES_VH

// =====================================================
// clock and timing
`define SIPG_CLK_PERIOD_NS      50
`define SIPG_INDEX_PULSE_NS     100
// least time, rounded up to whole cycles
`define SIPG_INDEX_PULSE_CYC    ((`SIPG_INDEX_PULSE_NS + `SIPG_CLK_PERIOD_NS - 1) / `SIPG_CLK_PERIOD_NS)
`define SIPG_PULSE_CNT_W        8

// =====================================================
// setup values
`define SIPG_DIRSEL_FWD_ONLY    1'h0
`define SIPG_DIRSEL_BOTH        1'h1
`define SIPG_ROT_CCW_FWD        1'h0
`define SIPG_USAGE_NONE         2'h0
`define SIPG_USAGE_FWD          2'h1
`define SIPG_USAGE_REV          2'h3

// =====================================================
// startup and reset values
`define SIPG_SETTLE_CYC         2'h3
`define SIPG_SETTLE_RST         2'h0
`define SIPG_PULSE_RST          1'h0
`define SIPG_VALID_RST          1'h0

`endif

// file: hw/sipg_index_gate.v
`timescale 1ns/100ps
`default_nettype none
`include "sipg_defines.vh"


module sipg_index_gate #(
    parameter CNT_W = 32,
    parameter MARKS = 4
) (
    // clock and reset
    input  wire             clk,
    input  wire             resetn,
    // scale count from the decoder, same clock
    input  wire             scaleStep,
    input  wire             scaleUp,
    // zero mark pin from the scale
    input  wire             zeroMark,
    // setup straps, taken once after restart
    input  wire             indexDirectionSelect,
    input  wire             rotationDirectionSelect,
    input  wire [1:0]       externalScaleUsage,
    input  wire             countDirOnlyScale,
    input  wire             serialConverter,
    // towards the host controller
    output reg              indexPulse,
    output reg  [CNT_W-1:0] fullclosedFeedbackCounter,
    output reg              setupDone
);

    // whole-cycle count worked out as an integer, then cut to the counter width
    localparam integer                 PULSE_CYC_I = `SIPG_INDEX_PULSE_CYC;
    localparam [`SIPG_PULSE_CNT_W-1:0] PULSE_CYC   = PULSE_CYC_I[`SIPG_PULSE_CNT_W-1:0];
    localparam [`SIPG_PULSE_CNT_W-1:0] PULSE_ONE = 8'h01;
    localparam [`SIPG_PULSE_CNT_W-1:0] PULSE_ZERO = 8'h00;
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam [MARKS-1:0] MARK_ONE = {{(MARKS-1){1'b0}}, 1'b1};
    localparam STRAP_W = 6;

    // =====================================================
    // pin synchronisers
    reg                 markS1_q;
    reg                 markS2_q;
    reg                 markS3_q;
    reg                 markLvl_q;
    reg [STRAP_W-1:0]   strapS1_q;
    reg [STRAP_W-1:0]   strapS2_q;
    reg [STRAP_W-1:0]   strapS3_q;
    wire [STRAP_W-1:0]  strapPins;
    wire                markEdge;

    assign strapPins = {serialConverter, countDirOnlyScale, externalScaleUsage,
                        rotationDirectionSelect, indexDirectionSelect};

    // stage one may go metastable, so only stages two and three are compared
    always @(posedge clk) begin
        if (!resetn) begin
            markS1_q <= 1'h0;
            markS2_q <= 1'h0;
            markS3_q <= 1'h0;
        end else begin
            markS1_q <= zeroMark;
            markS2_q <= markS1_q;
            markS3_q <= markS2_q;
        end
    end

    // straps are static in use, but still come from pins
    always @(posedge clk) begin
        if (!resetn) begin
            strapS1_q <= 6'h00;
            strapS2_q <= 6'h00;
            strapS3_q <= 6'h00;
        end else begin
            strapS1_q <= strapPins;
            strapS2_q <= strapS1_q;
            strapS3_q <= strapS2_q;
        end
    end

    // a level counts once stages two and three agree
    always @(posedge clk) begin
        if (!resetn) begin
            markLvl_q <= 1'h0;
        end else if (markS2_q == markS3_q) begin
            markLvl_q <= markS3_q;
        end
    end

    assign markEdge = (markS2_q == markS3_q) && markS3_q && !markLvl_q;

    // =====================================================
    // setup capture at restart
    localparam [1:0] SU_SETTLE = 2'h0;
    localparam [1:0] SU_AGREE  = 2'h1;
    localparam [1:0] SU_RUN    = 2'h2;

    reg [1:0]   suState_q;
    reg [1:0]   suState_d;
    reg [1:0]   settle_q;
    reg [1:0]   settle_d;
    reg         capture;
    reg         cfgBoth_q;
    reg         cfgRotRev_q;
    reg         cfgUsageRev_q;
    reg         cfgCountOnly_q;
    reg         cfgSerial_q;

    // settle first: the strap stages still hold their reset zeros
    always @* begin
        suState_d = suState_q;
        settle_d  = settle_q;
        capture   = 1'h0;
        case (suState_q)
            SU_SETTLE: begin
                if (settle_q == `SIPG_SETTLE_CYC) begin
                    suState_d = SU_AGREE;
                end else begin
                    settle_d = settle_q + 2'h1;
                end
            end
            SU_AGREE: begin
                // a strap still on the move is not taken
                if (strapS2_q == strapS3_q) begin
                    suState_d = SU_RUN;
                    capture   = 1'h1;
                end
            end
            SU_RUN: begin
                suState_d = SU_RUN;
            end
            default: begin
                suState_d = SU_SETTLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!resetn) begin
            suState_q      <= SU_SETTLE;
            settle_q       <= `SIPG_SETTLE_RST;
            setupDone      <= 1'h0;
            cfgBoth_q      <= `SIPG_DIRSEL_FWD_ONLY;
            cfgRotRev_q    <= `SIPG_ROT_CCW_FWD;
            cfgUsageRev_q  <= 1'h0;
            cfgCountOnly_q <= 1'h0;
            cfgSerial_q    <= 1'h0;
        end else begin
            suState_q <= suState_d;
            settle_q  <= settle_d;
            // later strap changes wait for the next restart
            if (capture) begin
                setupDone      <= 1'h1;
                cfgBoth_q      <= (strapS3_q[0] == `SIPG_DIRSEL_BOTH);
                cfgRotRev_q    <= (strapS3_q[1] != `SIPG_ROT_CCW_FWD);
                cfgUsageRev_q  <= (strapS3_q[3:2] == `SIPG_USAGE_REV);
                cfgCountOnly_q <= strapS3_q[4];
                cfgSerial_q    <= strapS3_q[5];
            end
        end
    end

    // =====================================================
    // direction and feedback counter
    wire                stepFwd;
    wire                revAllowed;
    reg                 lastFwd_q;
    reg                 lastFwd_d;
    reg                 revStep_q;
    reg [CNT_W-1:0]     fbCount_d;

    assign stepFwd = cfgCountOnly_q ? scaleUp
                                    : (scaleUp ^ cfgRotRev_q ^ cfgUsageRev_q);

    assign revAllowed = cfgBoth_q | cfgSerial_q;

    always @* begin
        fbCount_d = fullclosedFeedbackCounter;
        lastFwd_d = lastFwd_q;
        if (scaleStep) begin
            lastFwd_d = stepFwd;
            if (stepFwd) begin
                fbCount_d = fullclosedFeedbackCounter + CNT_ONE;
            end else begin
                fbCount_d = fullclosedFeedbackCounter - CNT_ONE;
            end
        end
    end

    // counts with no drive enabled, so hand moves are seen too
    always @(posedge clk) begin
        if (!resetn) begin
            fullclosedFeedbackCounter <= {CNT_W{1'b0}};
            lastFwd_q                 <= 1'h1;
            revStep_q                 <= 1'h0;
        end else begin
            // wraps silently; the host sees a plain modular count
            fullclosedFeedbackCounter <= fbCount_d;
            lastFwd_q                 <= lastFwd_d;
            revStep_q                 <= scaleStep && !stepFwd;
        end
    end

    // =====================================================
    // zero position table
    wire [MARKS-1:0]    entryValid;
    wire [MARKS-1:0]    entryHit;
    wire [MARKS-1:0]    freeVec;
    wire [MARKS-1:0]    allocOh;
    wire                anyHit;
    wire                fwdCross;
    wire                revCross;

    assign freeVec  = ~entryValid;
    // lowest free entry; all zero when the table is full
    assign allocOh  = freeVec & (~freeVec + MARK_ONE);
    assign anyHit   = |entryHit;
    assign fwdCross = setupDone && markEdge && lastFwd_q;
    // reverse only counts at an already latched position
    assign revCross = setupDone && revStep_q && anyHit && revAllowed;

    genvar i;
    generate
        for (i = 0; i < MARKS; i = i + 1) begin : g_mark
            reg             valid_q;
            reg [CNT_W-1:0] pos_q;

            assign entryValid[i] = valid_q;
            assign entryHit[i]   = valid_q && (pos_q == fullclosedFeedbackCounter);

            // each mark holds its own latch
            always @(posedge clk) begin
                if (!resetn) begin
                    valid_q <= `SIPG_VALID_RST;
                    pos_q   <= {CNT_W{1'b0}};
                end else if (fwdCross && !anyHit && allocOh[i]) begin
                    valid_q <= 1'h1;
                    pos_q   <= fullclosedFeedbackCounter;
                end
            end
        end
    endgenerate

    // =====================================================
    // index pulse output
    reg [`SIPG_PULSE_CNT_W-1:0] pulseCnt_q;
    reg [`SIPG_PULSE_CNT_W-1:0] pulseCnt_d;
    reg                         pulse_d;
    wire                        fire;

    // forward mark edge or reverse arrival at a latch
    // reverse fires at the latched place, not the reverse mark edge
    assign fire = fwdCross || revCross;

    // a fire during a pulse restarts the full width rather than merging
    always @* begin
        pulseCnt_d = pulseCnt_q;
        pulse_d    = indexPulse;
        if (fire) begin
            pulseCnt_d = PULSE_CYC;
            pulse_d    = 1'h1;
        end else if (pulseCnt_q > PULSE_ONE) begin
            pulseCnt_d = pulseCnt_q - PULSE_ONE;
        end else begin
            pulseCnt_d = PULSE_ZERO;
            pulse_d    = 1'h0;
        end
    end

    // output straight from a flop, no decode glitch towards the host
    always @(posedge clk) begin
        if (!resetn) begin
            pulseCnt_q <= PULSE_ZERO;
            indexPulse <= `SIPG_PULSE_RST;
        end else begin
            pulseCnt_q <= pulseCnt_d;
            indexPulse <= pulse_d;
        end
    end

endmodule

`default_nettype wire

// file: test/scale_index_pulse_gating_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// bench top
module scale_index_pulse_gating_tb_top;
    logic clk, resetn, stepReq, stepUp, sel, rot, only, conv, prevPulse;
    logic [1:0] usage;
    logic [31:0] nPulse, nFail, numChecks;
    wire logic scaleStep, scaleUp, zeroMark, indexPulse, setupDone;
    wire logic [31:0] fullclosedFeedbackCounter;
    sipg_scale_model model (.clk(clk), .resetn(resetn), .stepReq(stepReq), .stepUp(stepUp),
        .scaleStep(scaleStep), .scaleUp(scaleUp), .zeroMark(zeroMark));
    sipg_index_gate #(.CNT_W(32), .MARKS(4)) dut (.clk(clk), .resetn(resetn),
        .scaleStep(scaleStep), .scaleUp(scaleUp), .zeroMark(zeroMark),
        .indexDirectionSelect(sel), .rotationDirectionSelect(rot),
        .externalScaleUsage(usage), .countDirOnlyScale(only), .serialConverter(conv),
        .indexPulse(indexPulse), .fullclosedFeedbackCounter(fullclosedFeedbackCounter),
        .setupDone(setupDone));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // rising edges of the index output, cleared together with the block
    always @(posedge clk) begin
        prevPulse <= indexPulse;
        if (!resetn)
            nPulse <= 32'h0;
        else if (indexPulse === 1'h1 && prevPulse === 1'h0)
            nPulse <= nPulse + 32'h1;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        numChecks = numChecks + 32'h1;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            nFail = nFail + 32'h1;
        end
    endtask
    task automatic printVerdict;
        if (nFail == 32'h0 && numChecks != 32'h0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // steps spaced so the synchroniser sees every mark
    task automatic move(input logic up, input int n);
        repeat (n) begin
            stepReq = 1'h1;
            stepUp = up;
            @(negedge clk);
            stepReq = 1'h0;
            repeat (7) @(negedge clk);
        end
    endtask
    task automatic restart(input logic s, c, o, r, input logic [1:0] u);
        resetn = 1'h0;
        sel = s;
        conv = c;
        only = o;
        rot = r;
        usage = u;
        repeat (5) @(negedge clk);
        check(indexPulse, 32'h0);
        check(fullclosedFeedbackCounter, 32'h0);
        resetn = 1'h1;
        for (int k = 0; k < 20 && setupDone !== 1'h1; k++) @(negedge clk);
        check(setupDone, 32'h1);
    endtask
    // marks sit at -3 and -7 of the model's travel; pulse count is cumulative
    task automatic runCase(input logic s, c, o, r, input logic [31:0] eRev);
        restart(s, c, o, r, 2'h1);
        move(1'h0, 9);
        check(nPulse, 32'h0);
        check(fullclosedFeedbackCounter, 32'hfffffff7);
        move(1'h1, 8);
        check(nPulse, 32'h2);
        check(fullclosedFeedbackCounter, 32'hffffffff);
        move(1'h0, 8);
        check(nPulse, 32'h2 + eRev);
    endtask
    // counter runs against the model, so the model's reverse travel is forward
    task automatic runInverted(input logic r, input logic [1:0] u);
        restart(1'h0, 1'h0, 1'h0, r, u);
        move(1'h0, 9);
        check(nPulse, 32'h2);
        check(fullclosedFeedbackCounter, 32'h9);
        move(1'h1, 8);
        check(nPulse, 32'h2);
        check(fullclosedFeedbackCounter, 32'h1);
    endtask
    task automatic scnForwardOnly;
        runCase(1'h0, 1'h0, 1'h0, 1'h0, 32'h0);
    endtask
    task automatic scnBothWays;
        runCase(1'h1, 1'h0, 1'h0, 1'h0, 32'h2);
    endtask
    task automatic scnSerialConv;
        runCase(1'h0, 1'h1, 1'h0, 1'h0, 32'h2);
    endtask
    task automatic scnCountOnly;
        runCase(1'h0, 1'h0, 1'h1, 1'h1, 32'h0);
    endtask
    task automatic scnRotReverse;
        runInverted(1'h1, 2'h1);
    endtask
    task automatic scnUsageReverse;
        runInverted(1'h0, 2'h3);
    endtask
    initial begin
        {resetn, stepReq, stepUp} = 3'h0;
        {nFail, numChecks} = 64'h0;
        scnForwardOnly;
        scnBothWays;
        scnSerialConv;
        scnCountOnly;
        scnRotReverse;
        scnUsageReverse;
        printVerdict;
    end
    initial begin
        repeat (5000) @(posedge clk);
        nFail = nFail + 32'h1;
        printVerdict;
    end
endmodule
`default_nettype wire

// file: test/sipg_index_gate_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// index gate checks
module sipg_index_gate_asserts #(parameter CNT_W = 32) (
    input wire logic             clk,
    input wire logic             resetn,
    input wire logic             scaleStep,
    input wire logic             scaleUp,
    input wire logic             zeroMark,
    input wire logic             indexDirectionSelect,
    input wire logic             rotationDirectionSelect,
    input wire logic [1:0]       externalScaleUsage,
    input wire logic             countDirOnlyScale,
    input wire logic             serialConverter,
    input wire logic             indexPulse,
    input wire logic [CNT_W-1:0] fullclosedFeedbackCounter,
    input wire logic             setupDone
);
    logic      lastFwd_q;
    wire logic fwdStep = countDirOnlyScale ? scaleUp
        : scaleUp ^ rotationDirectionSelect ^ (externalScaleUsage == 2'h3);
    wire logic fwdOnly = !indexDirectionSelect && !serialConverter;
    always @(posedge clk) begin
        if (!resetn)
            lastFwd_q <= 1'h1;
        else if (scaleStep)
            lastFwd_q <= fwdStep;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_markHigh;
        !zeroMark ##1 zeroMark [*4];
    endsequence
    sequence s_fwdMark;
        s_markHigh ##0 (setupDone && lastFwd_q);
    endsequence
    sequence s_revMark;
        s_markHigh ##0 (!lastFwd_q && fwdOnly);
    endsequence
    a_counter_holds: assert property (!scaleStep |=> $stable(fullclosedFeedbackCounter))
        else $error("counter moved without a step");
    a_count_up: assert property (setupDone && scaleStep && fwdStep |=>
        fullclosedFeedbackCounter == $past(fullclosedFeedbackCounter) + 1)
        else $error("forward step not counted up");
    a_count_down: assert property (setupDone && scaleStep && !fwdStep |=>
        fullclosedFeedbackCounter == $past(fullclosedFeedbackCounter) - 1)
        else $error("reverse step not counted down");
    a_pulse_width: assert property ($rose(indexPulse) |=> indexPulse)
        else $error("index pulse too short");
    a_quiet_presetup: assert property (!setupDone |-> !indexPulse)
        else $error("index before setup");
    a_fwd_mark_fires: assert property (s_fwdMark |=> indexPulse)
        else $error("forward mark gave no index");
    a_rev_mark_quiet: assert property (s_revMark |=> !indexPulse)
        else $error("reverse mark gave index");
    a_fwd_only_cause: assert property ($rose(indexPulse) && fwdOnly |->
        $past(zeroMark, 4) && !$past(zeroMark, 5))
        else $error("index without forward mark");
endmodule
bind sipg_index_gate sipg_index_gate_asserts #(.CNT_W(CNT_W)) uChk (
    .clk(clk), .resetn(resetn), .scaleStep(scaleStep), .scaleUp(scaleUp),
    .zeroMark(zeroMark), .indexDirectionSelect(indexDirectionSelect),
    .rotationDirectionSelect(rotationDirectionSelect),
    .externalScaleUsage(externalScaleUsage), .countDirOnlyScale(countDirOnlyScale),
    .serialConverter(serialConverter), .indexPulse(indexPulse),
    .fullclosedFeedbackCounter(fullclosedFeedbackCounter), .setupDone(setupDone));
`default_nettype wire

// file: test/sipg_scale_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// scale head with two zero marks
module sipg_scale_model #(
    parameter MARK_A = 32'hfffffffd,
    parameter MARK_B = 32'hfffffff9
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // bench commands
    input  wire logic stepReq,
    input  wire logic stepUp,
    // towards the gate
    output var logic  scaleStep,
    output var logic  scaleUp,
    output wire logic zeroMark
);
    logic [31:0] pos_q;
    // mark is a level while the head sits on it
    assign zeroMark = (pos_q == MARK_A) || (pos_q == MARK_B);
    initial begin
        scaleStep = 1'h0;
        scaleUp = 1'h0;
        pos_q = 32'h0;
    end
    always @(posedge clk) begin
        scaleStep <= stepReq && resetn;
        scaleUp <= stepUp;
        if (!resetn)
            pos_q <= 32'h0;
        else if (stepReq)
            pos_q <= stepUp ? pos_q + 32'h1 : pos_q - 32'h1;
    end
endmodule
`default_nettype wire
